// [design/ctv_pkg.sv]
/*
  Package for the channel 3/4 trim and volume register bank: register
  offsets, field positions, reset values and the shared output carrier.
  Assumes byte-wide registers on an 8-bit register address space.
*/
package ctv_pkg;
  localparam int unsigned NUM_CH = 2;

  // register offsets
  localparam logic [7:0] OFS_CH3_VOLUME = 8'h48;
  localparam logic [7:0] OFS_CH3_GAIN_TRIM = 8'h49;
  localparam logic [7:0] OFS_CH3_PHASE_TRIM = 8'h4A;
  localparam logic [7:0] OFS_CH4_VOLUME = 8'h4D;
  localparam logic [7:0] OFS_CH4_GAIN_TRIM = 8'h4E;
  localparam logic [7:0] OFS_CH4_PHASE_TRIM = 8'h4F;
  localparam logic [7:0] OFS_PROC_CFG_ZERO = 8'h6B;

  // reset values
  localparam logic [7:0] RST_VOLUME = 8'hC9;
  localparam logic [7:0] RST_GAIN_TRIM = 8'h80;
  localparam logic [7:0] RST_PHASE_TRIM = 8'h00;
  localparam logic [7:0] RST_PROC_CFG_ZERO = 8'h01;

  // field layout of the gain trim register
  localparam int unsigned GAIN_TRIM_MSB = 7;
  localparam int unsigned GAIN_TRIM_LSB = 4;
  localparam logic [3:0] GAIN_TRIM_RSVD = 4'h0;

  // volume code points, in codes
  localparam logic [7:0] VOL_CODE_MUTE = 8'h00;
  localparam logic [7:0] VOL_CODE_UNITY = 8'hC9;
  // gain trim code of 0 dB
  localparam logic [3:0] TRIM_CODE_UNITY = 4'h8;

  // deepest phase delay in modulator cycles
  localparam int unsigned MAX_DELAY = 255;

  // per-channel result handed to the datapath
  typedef struct packed {
    logic mute;
    logic signed [8:0] level_half_db;
    logic signed [4:0] trim_tenth_db;
    logic ramping;
    logic mod_bit_delayed;
  } ctv_chan_out_s;
endpackage

// [design/ctv_regs.sv]
/*
  Trim and volume register bank for input channels 3 and 4, with the
  per-channel volume soft-step, gain trim decode and phase delay line.
  Assumes a byte-wide register port fed by the control interface decoder,
  a one-cycle sample strobe for soft-stepping and a one-cycle modulator
  clock strobe with one modulator bit per channel, all synchronous to mclk.
*/
// Behaviour
// - volume code zero mutes the channel output instead of attenuating.
// - volume code 1 gives -100 dB, code 2 gives -99.5 dB.
// - volume code 201 is 0 dB; higher codes raise level to +27 dB at 255.
// - volume code sits in bits 7..0 and resets to unity code 201.
// - gain trim in bits 7..4; code 0 is -0.8 dB, code 1 is -0.7 dB.
// - gain trim resets to code 8 (0 dB); code 15 gives +0.7 dB.
// - phase code delays channel by that many modulator cycles, 0 to 255.
// - phase code resets to zero, so no delay until programmed.
// - volume changes, mutes and unmutes ramp unless soft-step is disabled.
`timescale 1ns/100ps
module ctv_regs #(
  parameter int unsigned DELAY_DEPTH = ctv_pkg::MAX_DELAY
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // register port
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_rdata_valid,
  // control
  input wire logic soft_step_disable,
  input wire logic sample_tick,
  // modulator stream
  input wire logic mod_tick,
  input wire logic [ctv_pkg::NUM_CH-1:0] mod_bit_in,
  // per-channel results, index 0 is channel 3
  output ctv_pkg::ctv_chan_out_s [ctv_pkg::NUM_CH-1:0] chan_out,
  output logic [7:0] processing_config_zero
);

  // register storage
  logic [7:0] third_channel_volume_code_r;
  logic [7:0] third_channel_volume_code_nxt;
  logic [7:0] fourth_channel_volume_code_r;
  logic [7:0] fourth_channel_volume_code_nxt;
  logic [3:0] third_channel_gain_trim_code_r;
  logic [3:0] third_channel_gain_trim_code_nxt;
  logic [3:0] fourth_channel_gain_trim_code_r;
  logic [3:0] fourth_channel_gain_trim_code_nxt;
  logic [7:0] third_channel_delay_code_r;
  logic [7:0] third_channel_delay_code_nxt;
  logic [7:0] fourth_channel_delay_code_r;
  logic [7:0] fourth_channel_delay_code_nxt;
  logic [7:0] proc_cfg_zero_r;
  logic [7:0] proc_cfg_zero_nxt;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic rvalid_r;
  logic rvalid_nxt;

  // per-channel views for the generate loop
  logic [ctv_pkg::NUM_CH-1:0][7:0] vol_code;
  logic [ctv_pkg::NUM_CH-1:0][3:0] trim_code;
  logic [ctv_pkg::NUM_CH-1:0][7:0] delay_code;

  assign vol_code[0] = third_channel_volume_code_r;
  assign vol_code[1] = fourth_channel_volume_code_r;
  assign trim_code[0] = third_channel_gain_trim_code_r;
  assign trim_code[1] = fourth_channel_gain_trim_code_r;
  assign delay_code[0] = third_channel_delay_code_r;
  assign delay_code[1] = fourth_channel_delay_code_r;

  always_comb begin
    third_channel_volume_code_nxt = third_channel_volume_code_r;
    fourth_channel_volume_code_nxt = fourth_channel_volume_code_r;
    third_channel_gain_trim_code_nxt = third_channel_gain_trim_code_r;
    fourth_channel_gain_trim_code_nxt = fourth_channel_gain_trim_code_r;
    third_channel_delay_code_nxt = third_channel_delay_code_r;
    fourth_channel_delay_code_nxt = fourth_channel_delay_code_r;
    proc_cfg_zero_nxt = proc_cfg_zero_r;
    if (reg_wr_en) begin
      case (reg_addr)
        ctv_pkg::OFS_CH3_VOLUME: third_channel_volume_code_nxt = reg_wdata;
        ctv_pkg::OFS_CH4_VOLUME: fourth_channel_volume_code_nxt = reg_wdata;
        // low nibble is read-only; whatever software puts there is dropped
        ctv_pkg::OFS_CH3_GAIN_TRIM: begin
          third_channel_gain_trim_code_nxt =
            reg_wdata[ctv_pkg::GAIN_TRIM_MSB:ctv_pkg::GAIN_TRIM_LSB];
        end
        ctv_pkg::OFS_CH4_GAIN_TRIM: begin
          fourth_channel_gain_trim_code_nxt =
            reg_wdata[ctv_pkg::GAIN_TRIM_MSB:ctv_pkg::GAIN_TRIM_LSB];
        end
        ctv_pkg::OFS_CH3_PHASE_TRIM: third_channel_delay_code_nxt = reg_wdata;
        ctv_pkg::OFS_CH4_PHASE_TRIM: fourth_channel_delay_code_nxt = reg_wdata;
        ctv_pkg::OFS_PROC_CFG_ZERO: proc_cfg_zero_nxt = reg_wdata;
        default: begin
        end
      endcase
    end
  end

  // read path: one cycle after the strobe, unmapped offsets read zero
  always_comb begin
    rvalid_nxt = reg_rd_en;
    rdata_nxt = rdata_r;
    if (reg_rd_en) begin
      case (reg_addr)
        ctv_pkg::OFS_CH3_VOLUME: rdata_nxt = third_channel_volume_code_r;
        ctv_pkg::OFS_CH4_VOLUME: rdata_nxt = fourth_channel_volume_code_r;
        ctv_pkg::OFS_CH3_GAIN_TRIM: begin
          rdata_nxt = {third_channel_gain_trim_code_r, ctv_pkg::GAIN_TRIM_RSVD};
        end
        ctv_pkg::OFS_CH4_GAIN_TRIM: begin
          rdata_nxt = {fourth_channel_gain_trim_code_r, ctv_pkg::GAIN_TRIM_RSVD};
        end
        ctv_pkg::OFS_CH3_PHASE_TRIM: rdata_nxt = third_channel_delay_code_r;
        ctv_pkg::OFS_CH4_PHASE_TRIM: rdata_nxt = fourth_channel_delay_code_r;
        ctv_pkg::OFS_PROC_CFG_ZERO: rdata_nxt = proc_cfg_zero_r;
        default: rdata_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      third_channel_volume_code_r <= ctv_pkg::RST_VOLUME;
      fourth_channel_volume_code_r <= ctv_pkg::RST_VOLUME;
      third_channel_gain_trim_code_r <=
        ctv_pkg::RST_GAIN_TRIM[ctv_pkg::GAIN_TRIM_MSB:ctv_pkg::GAIN_TRIM_LSB];
      fourth_channel_gain_trim_code_r <=
        ctv_pkg::RST_GAIN_TRIM[ctv_pkg::GAIN_TRIM_MSB:ctv_pkg::GAIN_TRIM_LSB];
      third_channel_delay_code_r <= ctv_pkg::RST_PHASE_TRIM;
      fourth_channel_delay_code_r <= ctv_pkg::RST_PHASE_TRIM;
      proc_cfg_zero_r <= ctv_pkg::RST_PROC_CFG_ZERO;
    end else begin
      third_channel_volume_code_r <= third_channel_volume_code_nxt;
      fourth_channel_volume_code_r <= fourth_channel_volume_code_nxt;
      third_channel_gain_trim_code_r <= third_channel_gain_trim_code_nxt;
      fourth_channel_gain_trim_code_r <= fourth_channel_gain_trim_code_nxt;
      third_channel_delay_code_r <= third_channel_delay_code_nxt;
      fourth_channel_delay_code_r <= fourth_channel_delay_code_nxt;
      proc_cfg_zero_r <= proc_cfg_zero_nxt;
    end
  end

  // a read in the cycle of a write to the same offset returns the old byte
  always_ff @(posedge mclk) begin
    if (rst) begin
      rdata_r <= 8'h00;
      rvalid_r <= 1'b0;
    end else begin
      rdata_r <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
    end
  end

  assign reg_rdata = rdata_r;
  assign reg_rdata_valid = rvalid_r;
  assign processing_config_zero = proc_cfg_zero_r;

  // per-channel soft-step, decode and phase delay
  for (genvar ch = 0; ch < ctv_pkg::NUM_CH; ch++) begin : g_ch
    logic [7:0] applied_r;
    logic [7:0] applied_nxt;
    logic [DELAY_DEPTH-1:0] dline_r;
    logic [DELAY_DEPTH-1:0] dline_nxt;
    logic mod_out_r;
    logic mod_out_nxt;
    ctv_pkg::ctv_chan_out_s res_r;
    ctv_pkg::ctv_chan_out_s res_nxt;

    // the applied code walks one code (0.5 dB) per sample toward the
    // target; mute is code zero so unmute and mute ramp through code 1
    always_comb begin
      applied_nxt = applied_r;
      if (soft_step_disable) begin
        applied_nxt = vol_code[ch];
      end else if (sample_tick) begin
        if (applied_r < vol_code[ch]) begin
          applied_nxt = applied_r + 8'h01;
        end else if (applied_r > vol_code[ch]) begin
          applied_nxt = applied_r - 8'h01;
        end
      end
    end

    // tap 0 passes straight; tap n reads the bit n modulator cycles old
    always_comb begin
      dline_nxt = dline_r;
      mod_out_nxt = mod_out_r;
      if (mod_tick) begin
        dline_nxt = {dline_r[DELAY_DEPTH-2:0], mod_bit_in[ch]};
        if (delay_code[ch] == 8'h00) begin
          mod_out_nxt = mod_bit_in[ch];
        end else begin
          mod_out_nxt = dline_r[delay_code[ch] - 8'h01];
        end
      end
    end

    always_comb begin
      res_nxt.mute = (applied_nxt == ctv_pkg::VOL_CODE_MUTE);
      // code 1 -> -200 half-dB, code 201 -> 0, code 255 -> +54
      if (applied_nxt == ctv_pkg::VOL_CODE_MUTE) begin
        res_nxt.level_half_db = 9'sh000;
      end else begin
        res_nxt.level_half_db = $signed({1'b0, applied_nxt})
          - $signed({1'b0, ctv_pkg::VOL_CODE_UNITY});
      end
      res_nxt.trim_tenth_db = $signed({1'b0, trim_code[ch]})
        - $signed({1'b0, ctv_pkg::TRIM_CODE_UNITY});
      res_nxt.ramping = (applied_nxt != vol_code[ch]);
      res_nxt.mod_bit_delayed = mod_out_nxt;
    end

    always_ff @(posedge mclk) begin
      if (rst) begin
        applied_r <= ctv_pkg::RST_VOLUME;
      end else begin
        applied_r <= applied_nxt;
      end
    end

    // limitation: codes above DELAY_DEPTH would read past the line
    always_ff @(posedge mclk) begin
      if (rst) begin
        dline_r <= '0;
        mod_out_r <= 1'b0;
      end else begin
        dline_r <= dline_nxt;
        mod_out_r <= mod_out_nxt;
      end
    end

    always_ff @(posedge mclk) begin
      if (rst) begin
        res_r <= '0;
      end else begin
        res_r <= res_nxt;
      end
    end

    assign chan_out[ch] = res_r;
  end

endmodule

// [test/ctv_monitor.sv]
/*
  Port checker for the channel 3/4 trim and volume bank.
  Bound to every ctv_regs instance; sees only that module's ports.
*/
`timescale 1ns/100ps
module ctv_monitor #(
  parameter int unsigned DELAY_DEPTH = ctv_pkg::MAX_DELAY
) (
  // clock and reset
  input logic mclk,
  input logic rst,
  // register port
  input logic reg_wr_en,
  input logic reg_rd_en,
  input logic [7:0] reg_addr,
  input logic [7:0] reg_wdata,
  input logic [7:0] reg_rdata,
  input logic reg_rdata_valid,
  // control, stream and results
  input logic soft_step_disable,
  input logic sample_tick,
  input logic mod_tick,
  input logic [ctv_pkg::NUM_CH-1:0] mod_bit_in,
  input ctv_pkg::ctv_chan_out_s [ctv_pkg::NUM_CH-1:0] chan_out,
  input logic [7:0] processing_config_zero
);
  logic zero3_r;
  logic zero3_nxt;
  logic trim4_wr;
  // tracks whether channel 3 is programmed for no delay
  always_comb begin
    zero3_nxt = zero3_r;
    if (reg_wr_en && reg_addr == 8'h4A)
      zero3_nxt = (reg_wdata == 8'h00);
  end
  always_ff @(posedge mclk) begin
    zero3_r <= rst ? 1'b1 : zero3_nxt;
  end
  assign trim4_wr = reg_wr_en && reg_addr == 8'h4E;
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  AST_RD_LATENCY: assert property (reg_rd_en |=> reg_rdata_valid)
    else $error("read answer missing");
  AST_RD_HOLD: assert property ($changed(reg_rdata) |-> reg_rdata_valid)
    else $error("read data moved without a read");
  AST_RSVD_READ: assert property (
    reg_rd_en && (reg_addr == 8'h49 || reg_addr == 8'h4E) |=> reg_rdata[3:0] == 4'h0)
    else $error("trim low bits not zero");
  AST_MUTE_LEVEL: assert property (
    chan_out[1].mute |-> chan_out[1].level_half_db == 9'sd0)
    else $error("muted channel shows a level");
  AST_STEP_ONE: assert property (
    !soft_step_disable && !$past(soft_step_disable) && !$past(soft_step_disable, 2) &&
    !chan_out[1].mute && !$past(chan_out[1].mute) |->
    (chan_out[1].level_half_db - $past(chan_out[1].level_half_db)) inside {-9'sd1, 9'sd0, 9'sd1})
    else $error("level moved more than one step");
  AST_TICK_PACED: assert property (
    $changed(chan_out[1].level_half_db) && !soft_step_disable && !$past(soft_step_disable) &&
    !$past(soft_step_disable, 2) |-> $past(sample_tick) || $past(sample_tick, 2))
    else $error("level moved without a sample tick");
  AST_TRIM_WRITE: assert property (
    $changed(chan_out[1].trim_tenth_db) |-> $past(trim4_wr) || $past(trim4_wr, 2) ||
    $past(trim4_wr, 3))
    else $error("trim moved without a write");
  AST_DELAY_ZERO: assert property (
    mod_tick && zero3_r |=> chan_out[0].mod_bit_delayed == $past(mod_bit_in[0]))
    else $error("zero delay code delays the bit");
  AST_RESET_UNITY: assert property ($fell(rst) |=> chan_out[0].level_half_db == 9'sd0 &&
    chan_out[0].trim_tenth_db == 5'sd0 && !chan_out[0].mute)
    else $error("reset state is not unity");
endmodule
bind ctv_regs ctv_monitor #(.DELAY_DEPTH(DELAY_DEPTH)) u_mon (
  .mclk(mclk), .rst(rst), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .reg_rdata_valid(reg_rdata_valid), .soft_step_disable(soft_step_disable),
  .sample_tick(sample_tick), .mod_tick(mod_tick), .mod_bit_in(mod_bit_in),
  .chan_out(chan_out), .processing_config_zero(processing_config_zero)
);

// [test/testbench.sv]
/*
  Self-checking bench for the channel 3/4 trim and volume bank.
  Drives the byte register port, sample ticks and modulator stream itself.
*/
`timescale 1ns/100ps
module testbench;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic reg_wr_en = 1'b0;
  logic reg_rd_en = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata;
  logic reg_rdata_valid;
  logic soft_step_disable = 1'b0;
  logic sample_tick = 1'b0;
  logic mod_tick = 1'b0;
  logic [1:0] mod_bit_in = 2'h0;
  ctv_pkg::ctv_chan_out_s [ctv_pkg::NUM_CH-1:0] chan_out;
  logic [7:0] processing_config_zero;
  int err_count = 0;
  int checks_done = 0;
  always #5 mclk = ~mclk;
  ctv_regs dut (
    .mclk(mclk), .rst(rst), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rdata_valid(reg_rdata_valid), .soft_step_disable(soft_step_disable),
    .sample_tick(sample_tick), .mod_tick(mod_tick), .mod_bit_in(mod_bit_in),
    .chan_out(chan_out), .processing_config_zero(processing_config_zero)
  );
  task automatic chk(input logic [16:0] got, input logic [16:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // delayed bit is masked: it is judged only by the stream test
  function automatic logic [16:0] ch(input int i);
    return {chan_out[i][16:1], 1'b0};
  endfunction
  function automatic logic [16:0] co(input logic m, input logic signed [8:0] l,
    input logic signed [4:0] t, input logic r);
    return {m, l, t, r, 1'b0};
  endfunction
  task automatic idle(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_wr_en <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr_en <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge mclk);
    reg_rd_en <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd_en <= 1'b0;
    #1;
    chk({8'h00, reg_rdata_valid, reg_rdata}, {9'h001, e});
  endtask
  task automatic pulse(input int n);
    repeat (n) begin
      @(posedge mclk);
      sample_tick <= 1'b1;
      @(posedge mclk);
      sample_tick <= 1'b0;
    end
    idle(2);
  endtask
  task automatic run_ticks(input int n, input int imp, input int d3, input int d4);
    for (int i = 0; i <= n; i++) begin
      @(posedge mclk);
      mod_tick <= (i < n);
      mod_bit_in <= {2{i == imp}};
      #1;
      if (i > imp) begin
        chk({16'h0000, chan_out[0].mod_bit_delayed}, {16'h0000, i - 1 == imp + d3});
        chk({16'h0000, chan_out[1].mod_bit_delayed}, {16'h0000, i - 1 == imp + d4});
      end
    end
  endtask
  task automatic t_regs;
    logic [7:0] a [8] = '{8'h48, 8'h49, 8'h4A, 8'h4D, 8'h4E, 8'h4F, 8'h6B, 8'h4B};
    logic [7:0] e [8] = '{8'hC9, 8'h80, 8'h00, 8'hC9, 8'h80, 8'h00, 8'h01, 8'h00};
    // software keeps the read-only trim nibble at zero
    logic [7:0] w [4] = '{8'h00, 8'h10, 8'hF0, 8'h80};
    for (int i = 0; i < 8; i++) rd(a[i], e[i]);
    chk(ch(0), co(1'b0, 9'sd0, 5'sd0, 1'b0));
    for (int i = 0; i < 4; i++) begin
      wr(8'h4E, w[i]);
      rd(8'h4E, {w[i][7:4], 4'h0});
      idle(1);
      chk(ch(1), co(1'b0, 9'sd0, $signed({1'b0, w[i][7:4]}) - 5'sd8, 1'b0));
    end
    wr(8'h6B, 8'hA5);
    wr(8'h4B, 8'h5A);
    rd(8'h6B, 8'hA5);
    rd(8'h4B, 8'h00);
    chk({9'h000, processing_config_zero}, {9'h000, 8'hA5});
    $display("test registers done");
  endtask
  task automatic t_vol;
    logic [7:0] v [5] = '{8'h00, 8'h01, 8'h02, 8'hFF, 8'hC9};
    @(posedge mclk);
    soft_step_disable <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      wr(8'h48, v[i]);
      idle(3);
      chk(ch(0), co(v[i] == 8'h00,
        v[i] == 8'h00 ? 9'sd0 : $signed({1'b0, v[i]}) - 9'sd201, 5'sd0, 1'b0));
    end
    @(posedge mclk);
    soft_step_disable <= 1'b0;
    $display("test volume codes done");
  endtask
  task automatic t_ramp;
    wr(8'h4D, 8'hC7);
    idle(3);
    chk(ch(1), co(1'b0, 9'sd0, 5'sd0, 1'b1));
    pulse(1);
    chk(ch(1), co(1'b0, -9'sd1, 5'sd0, 1'b1));
    pulse(1);
    chk(ch(1), co(1'b0, -9'sd2, 5'sd0, 1'b0));
    wr(8'h4D, 8'h00);
    pulse(198);
    chk(ch(1), co(1'b0, -9'sd200, 5'sd0, 1'b1));
    pulse(1);
    chk(ch(1), co(1'b1, 9'sd0, 5'sd0, 1'b0));
    wr(8'h4D, 8'h03);
    idle(3);
    chk(ch(1), co(1'b1, 9'sd0, 5'sd0, 1'b1));
    pulse(1);
    chk(ch(1), co(1'b0, -9'sd200, 5'sd0, 1'b1));
    pulse(2);
    chk(ch(1), co(1'b0, -9'sd198, 5'sd0, 1'b0));
    $display("test soft step done");
  endtask
  task automatic t_delay;
    run_ticks(8, 2, 0, 0);
    wr(8'h4A, 8'h03);
    wr(8'h4F, 8'hFF);
    run_ticks(521, 260, 3, 255);
    $display("test phase delay done");
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    t_regs();
    t_vol();
    t_ramp();
    t_delay();
    print_verdict();
  end
  // the tests need about 1100 cycles; this allows several times that
  initial begin
    #100000;
    err_count++;
    print_verdict();
  end
endmodule
